// ==== design/msc_adc_ctrl.sv ====
// Purpose: Control of an 8-channel SAR ADC with serial host port
// Assumes: cmp_in is the comparator decision, high when input >= dac_code
// Notes: sdo is always driven; sdo_oe low only marks it as released
`timescale 1ns/1ps
`include "msc_defines.svh"
module msc_adc_ctrl
    import msc_pkg::*;
#(
    parameter int RES_BITS = `MSC_RES,
    parameter int CONV_CYCLES = `MSC_CONV_CYC,
    parameter int ACQ_CYCLES = `MSC_ACQ_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic conv_start_frame,
    input wire logic sck,
    input wire logic sdi,
    input wire logic cmp_in,
    output logic sdo,
    output logic sdo_oe,
    output logic [RES_BITS-1:0] dac_code,
    output logic [2:0] mux_pos,
    output logic [2:0] mux_neg,
    output logic mux_neg_gnd,
    output logic bipolar,
    output logic track,
    output logic busy,
    output logic nap,
    output logic sleep,
    output logic acq_short
);

    localparam int STEP = CONV_CYCLES / RES_BITS;
    localparam int PW = (STEP > 1) ? $clog2(STEP) : 1;
    localparam int IW = $clog2(RES_BITS);
    localparam int AW = $clog2(ACQ_CYCLES + 1);
    localparam int LW = $clog2(CONV_CYCLES + 1);

    if (!(RES_BITS == 12 || RES_BITS == 16) || STEP < 2 ||
        ACQ_CYCLES < 1) begin : g_bad_param
        $error("msc_adc_ctrl: unsupported parameter values");
    end

    // ============================================================
    // Helpers
    function automatic logic [RES_BITS-1:0] msc_decide(
        input logic [RES_BITS-1:0] code,
        input logic [IW-1:0] idx,
        input logic keep);
        logic [RES_BITS-1:0] mask;
        mask = RES_BITS'(1) << idx;
        return keep ? code : (code & ~mask);
    endfunction

    function automatic logic [RES_BITS-1:0] msc_fmt(
        input logic [RES_BITS-1:0] code,
        input logic bip);
        logic [RES_BITS-1:0] flip;
        flip = {bip, {(RES_BITS-1){1'b0}}};
        return code ^ flip;
    endfunction

    // ============================================================
    // Link port and crossings
    msc_link_if lnk ();

    msc_serial_port u_port (
        .sck(sck),
        .sys_rst(sys_rst),
        .conv_start_frame(conv_start_frame),
        .sdi(sdi),
        .lnk(lnk.link)
    );

    logic [2:0] frm_sync;
    logic frame_hi;
    logic start_edge;
    logic [2:0] tgl_sync;
    logic new_cfg;
    msc_cnt_t gry_s1;
    msc_cnt_t gry_s2;
    msc_cnt_t fall_cnt;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frm_sync <= 3'h7;
            frame_hi <= 1'b1;
        end else begin
            frm_sync <= {frm_sync[1:0], conv_start_frame};
            if (frm_sync[1] == frm_sync[2]) begin
                frame_hi <= frm_sync[2];
            end
        end
    end

    assign start_edge = frm_sync[1] & frm_sync[2] & ~frame_hi;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_sync <= 3'h0;
            gry_s1 <= '0;
            gry_s2 <= '0;
        end else begin
            tgl_sync <= {tgl_sync[1:0], lnk.cfg_tgl};
            gry_s1 <= lnk.fall_gray;
            gry_s2 <= gry_s1;
        end
    end

    assign new_cfg = tgl_sync[2] ^ tgl_sync[1];
    assign fall_cnt = msc_gray2bin(gry_s2);

    // ============================================================
    // Configuration: pending until the next start edge accepted in ST_ACQ
    msc_cfg_t pending;
    msc_cfg_t active;
    msc_cfg_t next_pending;
    msc_state_t state;
    logic accept;

    assign accept = start_edge && state == ST_ACQ;

    always_comb begin
        next_pending = pending;
        if (new_cfg) begin
            next_pending = lnk.cfg_word;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pending <= `MSC_CFG_RST;
            active <= `MSC_CFG_RST;
        end else begin
            pending <= next_pending;
            if (accept) begin
                active <= next_pending;
            end
        end
    end

    // ============================================================
    // Conversion sequencer
    logic [PW-1:0] phase;
    logic [IW-1:0] bit_idx;
    logic step_end;
    logic last_step;
    logic [RES_BITS-1:0] decided;
    logic [RES_BITS-1:0] result_q;

    assign step_end = phase == PW'(STEP - 1);
    assign last_step = state == ST_CONV && step_end && bit_idx == '0;
    assign decided = msc_decide(dac_code, bit_idx, cmp_in);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_ACQ;
        end else begin
            unique case (state)
                ST_ACQ: begin
                    if (accept) begin
                        state <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (last_step) begin
                        state <= frame_hi ? ST_NAP : ST_ACQ;
                    end
                end
                ST_NAP: begin
                    if (!frame_hi) begin
                        state <= ST_ACQ;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase <= '0;
            bit_idx <= '0;
            dac_code <= '0;
        end else if (accept) begin
            phase <= '0;
            bit_idx <= IW'(RES_BITS - 1);
            dac_code <= {1'b1, {(RES_BITS-1){1'b0}}};
        end else if (state == ST_CONV) begin
            phase <= step_end ? '0 : phase + PW'(1);
            if (step_end && bit_idx != '0) begin
                dac_code <= decided | (RES_BITS'(1) << (bit_idx - IW'(1)));
                bit_idx <= bit_idx - IW'(1);
            end else if (step_end) begin
                dac_code <= decided;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            result_q <= '0;
        end else if (last_step) begin
            result_q <= msc_fmt(decided, ~active[`MSC_CFG_POL]);
        end
    end

    // ============================================================
    // Acquisition time monitor
    logic [AW-1:0] acq_cnt;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acq_cnt <= AW'(ACQ_CYCLES);
            acq_short <= 1'b0;
        end else begin
            if (state == ST_CONV) begin
                acq_cnt <= '0;
            end else if (acq_cnt != AW'(ACQ_CYCLES)) begin
                acq_cnt <= acq_cnt + AW'(1);
            end
            if (accept) begin
                acq_short <= acq_cnt < AW'(ACQ_CYCLES);
            end
        end
    end

    // ============================================================
    // Multiplexer and mode outputs
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mux_pos <= 3'h0;
            mux_neg <= 3'h1;
            mux_neg_gnd <= 1'b0;
            bipolar <= 1'b1;
            sleep <= 1'b0;
        end else begin
            bipolar <= ~active[`MSC_CFG_POL];
            sleep <= active[`MSC_CFG_SLEEP] && state != ST_CONV;
            mux_pos <= {active[`MSC_CFG_A1], active[`MSC_CFG_A0],
                active[`MSC_CFG_ODD]};
            if (active[`MSC_CFG_SINGLE]) begin
                mux_neg <= `MSC_LAST_CH;
                mux_neg_gnd <= ~active[`MSC_CFG_COM];
            end else begin
                mux_neg <= {active[`MSC_CFG_A1], active[`MSC_CFG_A0],
                    ~active[`MSC_CFG_ODD]};
                mux_neg_gnd <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            track <= 1'b1;
            busy <= 1'b0;
            nap <= 1'b0;
        end else begin
            track <= state == ST_ACQ;
            busy <= state == ST_CONV;
            nap <= state == ST_NAP;
        end
    end

    // ============================================================
    // Serial data output
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= ~frame_hi && state != ST_CONV;
            if (int'(fall_cnt) < RES_BITS) begin
                sdo <= result_q[RES_BITS - 1 - int'(fall_cnt)];
            end else begin
                sdo <= 1'b0;
            end
        end
    end

    // ============================================================
    // Checks
    logic [LW-1:0] conv_len;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_len <= '0;
        end else if (state == ST_CONV) begin
            conv_len <= conv_len + LW'(1);
        end else begin
            conv_len <= '0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_start_conv: assert property (
        accept |=> state == ST_CONV ##1 busy)
        else $error("accepted start edge did not begin a conversion");

    a_no_restart: assert property (
        state == ST_CONV && !last_step |=>
            state == ST_CONV && $stable(active))
        else $error("running conversion was disturbed");

    a_conv_length: assert property (
        last_step |-> conv_len == LW'(RES_BITS * STEP - 1))
        else $error("conversion length wrong");

    a_msb_to_lsb: assert property (
        state == ST_CONV && step_end && bit_idx != '0 |=>
            bit_idx == $past(bit_idx) - IW'(1))
        else $error("bit decisions out of order");

    a_result_format: assert property (
        last_step |=> result_q[RES_BITS-1] ==
            ($past(decided[RES_BITS-1]) ^ ~$past(active[`MSC_CFG_POL])))
        else $error("result code format wrong");

    a_mux_pair: assert property (
        !active[`MSC_CFG_SINGLE] |=> !mux_neg_gnd &&
            mux_pos == {$past(active[`MSC_CFG_A1]),
            $past(active[`MSC_CFG_A0]), $past(active[`MSC_CFG_ODD])} &&
            mux_neg == (mux_pos ^ 3'h1))
        else $error("differential pair selection wrong");

    a_mux_common: assert property (
        active[`MSC_CFG_SINGLE] && active[`MSC_CFG_COM] |=>
            !mux_neg_gnd && mux_neg == `MSC_LAST_CH)
        else $error("common minus not selected");

    a_nap_entry: assert property (
        last_step && frame_hi |=> state == ST_NAP ##1 nap)
        else $error("nap not entered with frame high");

    a_msb_at_end: assert property (
        last_step && !frame_hi && fall_cnt == '0 |=> ##1
            sdo_oe && sdo == result_q[RES_BITS-1])
        else $error("MSB not presented at conversion end");

    a_cfg_applied: assert property (
        accept |=> active == $past(next_pending))
        else $error("new configuration not applied at start");

    a_acq_flag: assert property (
        accept && acq_cnt < AW'(ACQ_CYCLES) |=> acq_short)
        else $error("short acquisition not flagged");

    c_conversion: cover property (accept ##[1:1000] last_step);
    c_nap: cover property (state == ST_NAP ##1 state == ST_ACQ);
    c_new_cfg: cover property (new_cfg ##[1:1000] accept);
    c_msb_out: cover property (last_step && !frame_hi);

endmodule

// ==== design/msc_defines.svh ====
// Purpose: Constants of the multiplexed ADC serial control block
// Assumes: 200 MHz core clock; host drives frame, shift clock and data
// Notes: Times are kept as printed; cycle counts derive from them
//
// Operation
// - Frame rising edge starts a conversion
// - Start edges ignored while conversion runs
// - Frame pin starts conversions and frames transfers
// - Config in and result out share one frame
// - SAR resolves MSB to LSB, then latches result
// - Seven config bits, single/diff first, sleep last
// - Config word captured from serial input
// - Transfers timed only by host shift clock; code registers sdo on core_clk from the synchronised falling-edge count
// - Unipolar straight binary, bipolar two's complement
// - COM low: address picks pair, odd bit polarity; code picks the pair when single/diff is low, and COM low grounds minus when single/diff is high
// - COM high: last channel is shared minus; code does so only when single/diff is high
// - Config selects polarity mode and sleep request
// - Frame high after conversion enters nap
// - Frame low at end shows MSB, stays up
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH

// ============================================================
// Configuration word layout, first bit shifted in is bit 6
`define MSC_CFG_W 7
`define MSC_CFG_SINGLE 6
`define MSC_CFG_ODD 5
`define MSC_CFG_A1 4
`define MSC_CFG_A0 3
`define MSC_CFG_COM 2
`define MSC_CFG_POL 1
`define MSC_CFG_SLEEP 0
`define MSC_CFG_RST 7'h00
`define MSC_CFG_LAST 3'h6

// ============================================================
// Resolution and link counters
`define MSC_RES 16
`define MSC_CNT_W 5
`define MSC_CNT_MAX 5'h1f
`define MSC_LAST_CH 3'h7

// ============================================================
// Timing
`define MSC_CLK_PERIOD_PS 5000
`define MSC_T_CONV_NS 3000
`define MSC_T_ACQ_NS 1500
`define MSC_CONV_CYC ((`MSC_T_CONV_NS * 1000) / `MSC_CLK_PERIOD_PS)
`define MSC_ACQ_CYC \
    ((`MSC_T_ACQ_NS * 1000 + `MSC_CLK_PERIOD_PS - 1) / `MSC_CLK_PERIOD_PS)

`endif

// ==== design/msc_link_if.sv ====
// Purpose: Carrier between the shift-clock port and the core logic
// Assumes: Link side drives, core side reads cfg_tgl and fall_gray through synchronisers, cfg_word directly
// Notes: cfg_word is held stable while cfg_tgl crosses
`timescale 1ns/1ps
`include "msc_defines.svh"
interface msc_link_if;
    logic [`MSC_CFG_W-1:0] cfg_word;
    logic cfg_tgl;
    logic [`MSC_CNT_W-1:0] fall_gray;

    modport link (output cfg_word, output cfg_tgl, output fall_gray);
    modport core (input cfg_word, input cfg_tgl, input fall_gray);
endinterface

// ==== design/msc_pkg.sv ====
// Purpose: Types and shared helpers of the ADC serial control block
// Assumes: msc_defines.svh gives the widths
// Notes: Gray helpers serve the shift-clock counter crossing
`include "msc_defines.svh"
package msc_pkg;

    typedef enum logic [2:0] {
        ST_ACQ = 3'b001,
        ST_CONV = 3'b010,
        ST_NAP = 3'b100
    } msc_state_t;

    typedef logic [`MSC_CFG_W-1:0] msc_cfg_t;
    typedef logic [`MSC_CNT_W-1:0] msc_cnt_t;

    function automatic msc_cnt_t msc_bin2gray(input msc_cnt_t b);
        return b ^ (b >> 1);
    endfunction

    function automatic msc_cnt_t msc_gray2bin(input msc_cnt_t g);
        msc_cnt_t b;
        b[`MSC_CNT_W-1] = g[`MSC_CNT_W-1];
        for (int i = `MSC_CNT_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// ==== design/msc_serial_port.sv ====
// Purpose: Shift-clock side of the serial port
// Assumes: Shift clock only runs while the frame pin is low
// Notes: Frame high clears the per-frame counters asynchronously
`timescale 1ns/1ps
`include "msc_defines.svh"
module msc_serial_port
    import msc_pkg::*;
(
    input wire logic sck,
    input wire logic sys_rst,
    input wire logic conv_start_frame,
    input wire logic sdi,
    msc_link_if.link lnk
);

    logic frame_rst;
    logic [2:0] in_cnt;
    logic [`MSC_CFG_W-2:0] shreg;
    msc_cnt_t fall_bin;
    msc_cnt_t next_fall;

    // Idle frame ends every transfer without needing a clock edge
    assign frame_rst = sys_rst | conv_start_frame;
    assign next_fall = (fall_bin == `MSC_CNT_MAX) ? fall_bin :
        fall_bin + 5'h01;

    // ============================================================
    // Configuration shift-in on rising shift clock
    always_ff @(posedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            in_cnt <= 3'h0;
            shreg <= '0;
        end else if (in_cnt != `MSC_CFG_LAST + 3'h1) begin
            shreg <= {shreg[`MSC_CFG_W-3:0], sdi};
            in_cnt <= in_cnt + 3'h1;
        end
    end

    always_ff @(posedge sck or posedge sys_rst) begin
        if (sys_rst) begin
            lnk.cfg_word <= `MSC_CFG_RST;
            lnk.cfg_tgl <= 1'b0;
        end else if (in_cnt == `MSC_CFG_LAST) begin
            lnk.cfg_word <= {shreg, sdi};
            lnk.cfg_tgl <= ~lnk.cfg_tgl;
        end
    end

    // ============================================================
    // Result bit index advances on falling shift clock
    always_ff @(negedge sck or posedge frame_rst) begin
        if (frame_rst) begin
            fall_bin <= '0;
            lnk.fall_gray <= '0;
        end else begin
            fall_bin <= next_fall;
            lnk.fall_gray <= msc_bin2gray(next_fall);
        end
    end

    // ============================================================
    // Checks
    a_cfg_first_msb: assert property (
        @(posedge sck) disable iff (frame_rst)
        in_cnt == `MSC_CFG_LAST |=> lnk.cfg_word[`MSC_CFG_SINGLE] ==
            $past(shreg[`MSC_CFG_W-2]))
        else $error("first config bit not in top position");

    a_cfg_word_tgl: assert property (
        @(posedge sck) disable iff (frame_rst)
        in_cnt == `MSC_CFG_LAST |=> lnk.cfg_tgl != $past(lnk.cfg_tgl))
        else $error("complete config word not announced");

endmodule

// ==== testbench/msc_host_model.sv ====
// Purpose: Host serial controller driving frame, shift clock and data
// Assumes: Shift clock period 64 ns, idle low, runs only inside frames
// Notes: Tasks are called from the testbench top
`timescale 1ns/1ps
module msc_host_model (
    input wire logic core_clk,
    input wire logic sdo,
    output logic conv_start_frame,
    output logic sck,
    output logic sdi
);
    initial begin
        conv_start_frame = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end

    // ============================================================
    // Framed exchange: config word in, result out
    task automatic xfer(input logic [6:0] cfg, input int npulse,
                        output logic [15:0] res);
        res = 16'h0000;
        @(posedge core_clk);
        conv_start_frame <= 1'b0;
        #101.3;
        for (int i = 0; i < npulse; i++) begin
            // Spare pulses carry a toggling pattern, not the last bit
            sdi <= (i < 7) ? cfg[6-i] : ~sdi;
            #32;
            sck <= 1'b1;
            res = {res[14:0], sdo};
            #32;
            sck <= 1'b0;
        end
        #64;
        @(posedge core_clk);
        conv_start_frame <= 1'b1;
    endtask

    // ============================================================
    // Frame low for a few core cycles with no shift clock
    task automatic pulse(input int low_cyc, input logic end_lvl);
        @(posedge core_clk);
        conv_start_frame <= 1'b0;
        repeat (low_cyc) @(posedge core_clk);
        conv_start_frame <= 1'b1;
        if (!end_lvl) begin
            repeat (low_cyc) @(posedge core_clk);
            conv_start_frame <= 1'b0;
        end
    endtask
endmodule

// ==== testbench/test_msc_adc_ctrl.sv ====
// Purpose: Self-checking bench of the ADC serial control block
// Assumes: Comparator model keeps a trial bit while code <= target
// Notes: Short conversion and acquisition counts keep the run brief
`timescale 1ns/1ps
module test_msc_adc_ctrl
    import msc_pkg::*;
;
    typedef struct packed {
        logic [6:0] cfg;
        logic [15:0] tgt;
        logic [2:0] pos;
        logic [2:0] neg;
        logic gnd;
        logic bip;
        logic sleep_request;
    } msc_row_t;

    logic core_clk, sys_rst, conv_start_frame, sck, sdi, cmp_in;
    logic sdo, sdo_oe, mux_neg_gnd, bipolar, track, busy, nap, sleep;
    logic acq_short, sdo_line;
    logic [15:0] dac_code, target, got, prev_exp;
    logic [2:0] mux_pos, mux_neg;
    int n_mismatch = 0;
    int num_checks = 0;
    int nbusy;
    msc_row_t rows [6];

    msc_adc_ctrl #(.RES_BITS(16), .CONV_CYCLES(64), .ACQ_CYCLES(16))
    i_msc_adc_ctrl (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .conv_start_frame(conv_start_frame), .sck(sck), .sdi(sdi),
        .cmp_in(cmp_in), .sdo(sdo), .sdo_oe(sdo_oe),
        .dac_code(dac_code), .mux_pos(mux_pos), .mux_neg(mux_neg),
        .mux_neg_gnd(mux_neg_gnd), .bipolar(bipolar), .track(track),
        .busy(busy), .nap(nap), .sleep(sleep), .acq_short(acq_short)
    );

    msc_host_model i_msc_host_model (
        .core_clk(core_clk), .sdo(sdo_line),
        .conv_start_frame(conv_start_frame), .sck(sck), .sdi(sdi)
    );

    // Released output shows the inverse, so a late enable is caught
    assign sdo_line = sdo_oe ? sdo : ~sdo;

    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;

    // Comparator stand-in: analog input sits at target
    always @(posedge core_clk) cmp_in <= (dac_code <= target);

    // ============================================================
    // Checking and verdict
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 2000) begin
            @(posedge core_clk);
            n++;
        end
        #1;
        chk(busy, lvl);
    endtask

    task automatic check_idle();
        chk({sdo_oe, busy, track, nap, mux_neg_gnd, bipolar, sleep,
             acq_short}, 16'h0024);
        chk({mux_pos, mux_neg}, 16'h0001);
        chk(dac_code, 16'h0000);
    endtask

    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end

    // ============================================================
    // Main sequence
    initial begin
        rows[0] = {7'b0000010, 16'h1234, 3'h0, 3'h1, 1'b0, 1'b0, 1'b0};
        rows[1] = {7'b0111000, 16'h8001, 3'h7, 3'h6, 1'b0, 1'b1, 1'b0};
        rows[2] = {7'b1101010, 16'h00ff, 3'h3, 3'h7, 1'b1, 1'b0, 1'b0};
        rows[3] = {7'b1010110, 16'hffff, 3'h4, 3'h7, 1'b0, 1'b0, 1'b0};
        rows[4] = {7'b1110100, 16'h0000, 3'h5, 3'h7, 1'b0, 1'b1, 1'b0};
        rows[5] = {7'b0001011, 16'h5a5a, 3'h2, 3'h3, 1'b0, 1'b0, 1'b1};
        sys_rst = 1'b1;
        target = 16'h0000;
        prev_exp = 16'h0000;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1;
        check_idle();
        for (int i = 0; i < 6; i++) begin
            target <= rows[i].tgt;
            i_msc_host_model.xfer(rows[i].cfg, 16, got);
            if (i > 0)
                chk(got, prev_exp);
            wait_busy(1'b1);
            chk(acq_short, 1'b0);
            chk(track, 1'b0);
            wait_busy(1'b0);
            repeat (3) @(posedge core_clk);
            #1;
            chk({mux_pos, mux_neg, mux_neg_gnd},
                {rows[i].pos, rows[i].neg, rows[i].gnd});
            chk({bipolar, sleep}, {rows[i].bip, rows[i].sleep_request});
            chk({nap, track, sdo_oe}, 16'h0004);
            prev_exp = rows[i].bip ? (rows[i].tgt ^ 16'h8000)
                                   : rows[i].tgt;
        end

        // Restart attempt mid-conversion, frame low at the end
        target <= 16'hc3a5;
        i_msc_host_model.xfer(rows[0].cfg, 16, got);
        chk(got, prev_exp);
        wait_busy(1'b1);
        nbusy = 0;
        fork
            i_msc_host_model.pulse(4, 1'b0);
            while (busy === 1'b1 && nbusy < 200) begin
                @(posedge core_clk);
                #1;
                nbusy++;
            end
        join
        chk((nbusy >= 60 && nbusy <= 68), 1'b1);
        repeat (4) @(posedge core_clk);
        #1;
        chk({sdo_oe, nap, track, sdo}, 16'h000b);
        i_msc_host_model.xfer(rows[1].cfg, 16, got);
        chk(got, 16'hc3a5);
        wait_busy(1'b1);
        wait_busy(1'b0);

        // Start too soon after the end, with a frame too short for config
        i_msc_host_model.pulse(3, 1'b1);
        wait_busy(1'b1);
        chk(acq_short, 1'b1);
        #1;
        chk(mux_pos, 3'h7);

        // Reset in mid-conversion
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        check_idle();
        @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1;
        check_idle();
        print_verdict();
    end
endmodule
